//--- branch_incr_exec.sv
// Execution unit for the absolute branch and the register increment
`timescale 1ns/1ns
// Overview of operation
// - Branch loads target into PC 20..1
// - Any 20-bit literal target accepted
// - Low byte first word, upper bits second
// - Branch two cycles, second does nothing
// - Decode 0010 10da as register increment
// - Destination bit picks working or file
// - Access bit picks access or selected bank
// - Extended set, low access-bank addresses use indexing
// - Increment updates C DC N OV Z
module branch_incr_exec
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // Instruction words from fetch, stable over the cycle
  input wire logic [15:0] INSTR_WORD,
  input wire logic [15:0] NEXT_WORD,
  input wire logic EXT_SET_EN,
  input wire logic [3:0] BANK_SELECT_REGISTER,
  input wire logic [11:0] INDEX_BASE,
  // Data memory
  output mem_req_t MEM_REQ,
  input wire logic [7:0] MEM_RDATA,
  // Core state
  output logic [PC_W-1:0] PC,
  output logic [7:0] WREG,
  output flags_t FLAGS,
  output phase_t PHASE,
  output logic BUSY_NOP
);
  phase_t phase_ff, nxt_phase;
  logic [PC_W-1:0] pc_ff;
  logic [7:0] w_ff, data_ff, result_ff;
  flags_t flags_ff;
  mem_req_t req_ff;
  logic nop_ff;
  logic [TGT_LO_W-1:0] tgt_lo_ff;

  wire is_branch = !nop_ff && (INSTR_WORD[15:8] == {OPC_BRANCH_HI, 2'b11}) && (NEXT_WORD[15:12] == OPC_EXT_HI);
  wire is_incr = !nop_ff && (INSTR_WORD[15:10] == OPC_INCR_HI);
  wire dest_file = INSTR_WORD[D_BIT];
  wire bank_sel = INSTR_WORD[A_BIT];
  wire [7:0] faddr = INSTR_WORD[7:0];
  wire indexed = !bank_sel && EXT_SET_EN && (faddr <= INDEX_LIMIT);
  wire [11:0] idx_addr = INDEX_BASE + {4'h0, faddr};
  // Upper part of the access bank reaches the special register bank
  wire [11:0] acc_addr = (faddr >= ACCESS_HI_BASE) ? {ACCESS_HI_BANK, faddr} : {BANK0, faddr};
  wire [11:0] eff_addr = bank_sel ? {BANK_SELECT_REGISTER, faddr} : (indexed ? idx_addr : acc_addr);
  wire [8:0] sum = {1'b0, data_ff} + 9'h001;
  wire [4:0] nib = {1'b0, data_ff[3:0]} + 5'h01;
  wire [TGT_W-1:0] target = {NEXT_WORD[TGT_HI_W-1:0], tgt_lo_ff};

  always_comb begin
    case (phase_ff)
      Q1: nxt_phase = Q2;
      Q2: nxt_phase = Q3;
      Q3: nxt_phase = Q4;
      Q4: nxt_phase = Q1;
      default: nxt_phase = Q1;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_ff <= Q1;
      pc_ff <= '0;
      w_ff <= 8'h00;
      data_ff <= 8'h00;
      result_ff <= 8'h00;
      flags_ff <= '0;
      req_ff <= '0;
      nop_ff <= 1'b0;
      tgt_lo_ff <= 8'h00;
    end else if (CLK_EN) begin
      phase_ff <= nxt_phase;
      req_ff.rd <= 1'b0;
      req_ff.wr <= 1'b0;
      case (phase_ff)
        Q1: begin
          // Address latched at decode so the read happens in Q2
          if (is_incr) begin
            req_ff.rd <= 1'b1;
            req_ff.addr <= eff_addr;
          end
        end
        Q2: begin
          if (is_incr) begin
            data_ff <= MEM_RDATA;
          end
          if (is_branch) begin
            tgt_lo_ff <= INSTR_WORD[TGT_LO_W-1:0];
          end
        end
        Q3: begin
          if (is_incr) begin
            result_ff <= sum[7:0];
            flags_ff.carry <= sum[8];
            flags_ff.dcarry <= nib[4];
            flags_ff.zero <= (sum[7:0] == 8'h00);
            flags_ff.neg <= sum[7];
            // Only 7F to 80 can overflow an increment
            flags_ff.ovf <= !data_ff[7] && sum[7];
          end
        end
        Q4: begin
          if (is_incr) begin
            if (dest_file) begin
              req_ff.wr <= 1'b1;
              req_ff.wdata <= result_ff;
            end else begin
              w_ff <= result_ff;
            end
            pc_ff <= pc_ff + PC_W'(2);
          end else if (is_branch) begin
            pc_ff <= {target, 1'b0};
          end else if (!nop_ff) begin
            // Forced no-op leaves PC on the branch target
            pc_ff <= pc_ff + PC_W'(2);
          end
          nop_ff <= is_branch;
        end
        default: begin
          nop_ff <= 1'b0;
        end
      endcase
    end
  end

  assign PC = pc_ff;
  assign WREG = w_ff;
  assign FLAGS = flags_ff;
  assign PHASE = phase_ff;
  assign BUSY_NOP = nop_ff;
  assign MEM_REQ = req_ff;

  // Branch target comes from the latched low byte and the second word
  branch_pc_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q4 && is_branch) |=> (pc_ff[0] == 1'b0) && (pc_ff[PC_W-1:1] == $past(target)))
    else $error("branch target not loaded");
  branch_flags_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q4 && is_branch) |=> $stable(flags_ff))
    else $error("branch changed flags");
  branch_low_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q2 && is_branch) |=> tgt_lo_ff == $past(INSTR_WORD[TGT_LO_W-1:0]))
    else $error("branch low byte not latched");

  sequence nop_cycle_s;
    nop_ff && !req_ff.wr && !req_ff.rd;
  endsequence
  sequence nop_q4_s;
    CLK_EN && phase_ff == Q4 && nop_ff;
  endsequence
  branch_nop_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q4 && is_branch) |=> nop_cycle_s)
    else $error("second branch cycle not idle");
  nop_ignore_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q1 && nop_ff) |=> !req_ff.rd && !req_ff.wr)
    else $error("instruction ran in forced no-op");
  nop_pc_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    nop_q4_s |=> $stable(pc_ff))
    else $error("PC moved in forced no-op");
  nop_end_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    nop_q4_s |=> !nop_ff)
    else $error("forced no-op did not end");

  incr_read_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q1 && is_incr) |=> req_ff.rd && req_ff.addr == $past(eff_addr))
    else $error("read not issued in Q2");
  bank_addr_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q1 && is_incr && bank_sel) |=> req_ff.addr[11:8] == $past(BANK_SELECT_REGISTER))
    else $error("bank select not used");
  access_addr_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q1 && is_incr && !bank_sel && !indexed) |=> req_ff.addr[7:0] == $past(faddr)
      && ((req_ff.addr[11:8] == ACCESS_HI_BANK && req_ff.addr[7:0] >= ACCESS_HI_BASE)
      || (req_ff.addr[11:8] == BANK0 && req_ff.addr[7:0] < ACCESS_HI_BASE)))
    else $error("access bank address wrong");
  index_addr_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q1 && is_incr && indexed) |=> req_ff.addr == $past(idx_addr))
    else $error("indexed address wrong");
  rd_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && req_ff.rd) |=> !req_ff.rd)
    else $error("read request stood too long");

  incr_value_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q3 && is_incr) |=> result_ff == $past(data_ff) + 8'h01)
    else $error("increment result wrong");
  incr_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q3 && is_incr && data_ff == 8'hFF) |=> flags_ff.zero && flags_ff.carry && flags_ff.dcarry)
    else $error("wrap flags wrong");
  incr_flags_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q3 && is_incr) |=> flags_ff.carry == ($past(data_ff) == 8'hFF)
      && flags_ff.dcarry == ($past(data_ff[3:0]) == 4'hF) && flags_ff.ovf == ($past(data_ff) == 8'h7F)
      && flags_ff.neg == result_ff[7] && flags_ff.zero == (result_ff == 8'h00))
    else $error("increment flags wrong");

  // Write data in Q4 is the Q3 result, so use the latched copy
  incr_wreg_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q4 && is_incr && !dest_file) |=> w_ff == $past(result_ff) && !req_ff.wr)
    else $error("working register not written");
  incr_file_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q4 && is_incr && dest_file) |=> req_ff.wr && req_ff.wdata == $past(result_ff))
    else $error("file write missing");
  wr_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && req_ff.wr) |=> !req_ff.wr)
    else $error("write request stood too long");
  incr_pc_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (CLK_EN && phase_ff == Q4 && is_incr) |=> pc_ff == $past(pc_ff) + PC_W'(2))
    else $error("increment did not advance PC");

  // Clock enable low must leave phase, PC, flags, W and the no-op flag as they were
  clk_freeze_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !CLK_EN |=> $stable(phase_ff) && $stable(pc_ff) && $stable(flags_ff) && $stable(w_ff) && $stable(nop_ff))
    else $error("state moved with clock enable low");
  phase_step_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN |=> phase_ff == 2'($past(phase_ff) + 2'b01))
    else $error("phase did not advance");
endmodule : branch_incr_exec

//--- branch_incr_exec_tb.sv
// Self-checking bench for the branch and increment unit
`timescale 1ns/1ns
module branch_incr_exec_tb;
  import exec_pkg::*;
  logic clk = 0, rstn = 0, ext = 0, bz = 0, en = 1, nop;
  logic [15:0] lf = 16'h0020;
  logic [15:0] iw = 0, nw = 0;
  logic [3:0] bank_select_register = 0;
  logic [11:0] ib = 0, la = 0;
  logic [7:0] mem [4096], em [4096], w = 0, dw;
  logic [20:0] pc = 0, dpc;
  flags_t fl = '0, dfl;
  mem_req_t req;
  phase_t ph;
  logic [7:0] bv [4] = '{8'hFF, 8'h7F, 8'h0F, 8'hFF};
  logic [19:0] bt [3] = '{20'hFFFFF, 20'h00000, 20'h5A5A5};
  int bad_count = 0, num_checks = 0, hold = 0;
  always #5 clk = ~clk;
  branch_incr_exec dut (.REF_CLK(clk), .RESETN(rstn), .CLK_EN(en), .INSTR_WORD(iw), .NEXT_WORD(nw),
    .EXT_SET_EN(ext), .BANK_SELECT_REGISTER(bank_select_register), .INDEX_BASE(ib), .MEM_REQ(req),
    .MEM_RDATA(mem[req.addr]), .PC(dpc), .WREG(dw), .FLAGS(dfl), .PHASE(ph), .BUSY_NOP(nop));
  // Bench memory takes the design's writes
  always @(posedge clk) if (req.wr) mem[req.addr] <= req.wdata;
  function automatic logic [15:0] step(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step
  task automatic chk(string n, logic [20:0] e, logic [20:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Checks land one edge into the next slot, once the previous write has settled
  task automatic run(logic [15:0] i, logic [15:0] n);
    logic [11:0] ad;
    logic [7:0] v, r;
    iw = i;
    nw = n;
    @(negedge clk);
    chk("pc", pc, dpc);
    chk("wreg", w, dw);
    chk("flags", fl, dfl);
    chk("mem", em[la], mem[la]);
    chk("busy", bz, nop);
    chk("phase", Q2, ph);
    if (hold > 0) begin
      en = 0;
      repeat (hold) @(negedge clk);
      chk("phase frozen", Q2, ph);
      chk("pc frozen", pc, dpc);
      en = 1;
    end
    if (bz) bz = 0;
    else if (i[15:10] == OPC_BRANCH_HI) begin
      pc = {n[11:0], i[7:0], 1'b0};
      bz = 1;
    end else begin
      ad = i[A_BIT] ? {bank_select_register, i[7:0]} : (ext && i[7:0] <= INDEX_LIMIT) ? ib + i[7:0] :
        {(i[7:0] >= ACCESS_HI_BASE) ? ACCESS_HI_BANK : BANK0, i[7:0]};
      v = em[ad];
      r = v + 8'h01;
      fl = '{neg: r[7], ovf: v == 8'h7F, zero: r == 8'h00, dcarry: v[3:0] == 4'hF, carry: v == 8'hFF};
      if (i[D_BIT]) em[ad] = r;
      else w = r;
      la = ad;
      pc = pc + 21'h000002;
    end
    repeat (3) @(negedge clk);
  endtask : run
  initial begin
    for (int j = 0; j < 4096; j++) begin
      lf = step(lf);
      mem[j] = lf[7:0];
      em[j] = lf[7:0];
    end
    repeat (2) @(negedge clk);
    rstn = 1;
    for (int j = 0; j < 64; j++) begin
      lf = step(lf);
      bank_select_register = lf[3:0];
      ib = lf[15:4];
      ext = lf[14];
      run({OPC_INCR_HI, lf[9:0]}, 16'hFFFF);
    end
    $display("test random increments done");
    ext = 0;
    run({OPC_INCR_HI, 10'h000}, 16'hFFFF);
    foreach (bv[k]) begin
      hold = k;
      mem[96 + k] = bv[k];
      em[96 + k] = bv[k];
      run({OPC_INCR_HI, k[0], 1'b0, 8'(96 + k)}, 16'hFFFF);
    end
    $display("test flag boundaries done");
    foreach (bt[k]) begin
      hold = 0;
      run({OPC_BRANCH_HI, 2'b11, bt[k][7:0]}, {OPC_EXT_HI, bt[k][19:8]});
      hold = 2;
      run({OPC_INCR_HI, 10'h3FF}, 16'hFFFF);
    end
    hold = 0;
    run({OPC_INCR_HI, 10'h0A5}, 16'hFFFF);
    run({OPC_INCR_HI, 10'h0A5}, 16'hFFFF);
    $display("test branches done");
    complete_run();
  end
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule : branch_incr_exec_tb

//--- exec_pkg.sv
// Shared constants and types for the branch and increment execution unit
package exec_pkg;
  localparam int PC_W = 21;
  localparam int TGT_W = 20;
  localparam int TGT_LO_W = 8;
  localparam int TGT_HI_W = 12;
  localparam logic [5:0] OPC_BRANCH_HI = 6'h3B;
  localparam logic [5:0] OPC_INCR_HI = 6'h0A;
  localparam logic [3:0] OPC_EXT_HI = 4'hF;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  localparam logic [7:0] ACCESS_HI_BASE = 8'hA0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] BANK0 = 4'h0;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } phase_t;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcarry;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage : exec_pkg
